// ---- icm_pkg.sv ----
// Shared constants and types for the two-wire master clocking block
package icm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] OFS_RX     = 16'h0200;
  localparam logic [15:0] OFS_TX     = 16'h0202;
  localparam logic [15:0] OFS_RELOAD = 16'h0204;
  localparam logic [15:0] OFS_CTRL   = 16'h0206;
  localparam logic [15:0] OFS_STAT   = 16'h0208;
  localparam logic [15:0] OFS_ADDR   = 16'h020a;
  localparam logic [15:0] OFS_EVT    = 16'h020c;
  localparam logic [15:0] OFS_MASK   = 16'h020e;

  localparam logic [15:0] RST_RX     = 16'h0000;
  localparam logic [15:0] RST_TX     = 16'h00ff;
  localparam logic [15:0] RST_RELOAD = 16'h0000;
  localparam logic [15:0] RST_CTRL   = 16'h1000;
  localparam logic [15:0] RST_STAT   = 16'h0000;
  localparam logic [15:0] RST_ADDR   = 16'h0000;
  localparam logic [15:0] ADDR_WMASK = 16'h03ff;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN    = 15;
  localparam int CTRL_SIDL  = 13;
  localparam int CTRL_ACKDT = 5;
  localparam int CTRL_ACKEN = 4;
  localparam int CTRL_RCEN  = 3;
  localparam int CTRL_PEN   = 2;
  localparam int CTRL_RSEN  = 1;
  localparam int CTRL_SEN   = 0;
  localparam logic [15:0] CTRL_REQ_MASK = 16'h001f;

  localparam int STAT_ACK    = 15;
  localparam int STAT_TXACT  = 14;
  localparam int STAT_COLL   = 10;
  localparam int STAT_STOP   = 4;
  localparam int STAT_START  = 3;
  localparam int STAT_RXFULL = 1;
  localparam int STAT_TXFULL = 0;

  localparam int EVT_MASTER = 0;
  localparam int EVT_COLL   = 1;
  localparam int EVT_STOP   = 2;
  localparam int EVT_START  = 3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_HZ      = 100000000;
  localparam int          SCL_MAX_HZ  = 1000000;
  localparam logic [15:0] MIN_RELOAD  = 16'h0002;
  localparam logic [3:0]  LAST_BIT    = 4'h7;
  localparam logic [3:0]  ACK_BIT     = 4'h8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_RESTART, ST_STOP, ST_TX, ST_RX, ST_ACK
  } icm_fsm_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } icm_line_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } icm_req_t;

  typedef struct packed {
    icm_fsm_t    fsm;
    logic [1:0]  ph;
    logic [3:0]  bitn;
    logic [15:0] cnt;
    logic        wait_hi;
    logic [7:0]  shift;
    logic [7:0]  rx_data;
    logic [7:0]  tx_data;
    logic [15:0] reload;
    logic [15:0] ctrl;
    logic [9:0]  own_addr;
    logic        ackstat;
    logic        txact;
    logic        coll;
    logic        stop_seen;
    logic        start_seen;
    logic        rx_full;
    logic        tx_full;
    logic        lost;
    logic [3:0]  evt;
    logic [3:0]  mask;
    logic [2:0]  scl_sync;
    logic [2:0]  sda_sync;
    logic        scl_f;
    logic        sda_f;
    logic        sda_prev;
    logic        scl_oe;
    logic        sda_oe;
    logic        ev_pulse;
    logic        irq;
    logic [15:0] rdata;
  } icm_state_t;

endpackage

// ---- icm_master.sv ----
// Two-wire master clock generator, arbitration and bus monitor
//
// Overview of operation
// RL1: Clock counter loads the reload value, counts down to zero, then reloads and counts down again.
// RL2: Software never programs reload values zero or one.
// RL3: Any serial clock rate up to 1 MHz is reachable.
// RL4: Software derives the reload value from the clock ratio formula.
// RL5: Counter pauses while a released clock line is not yet seen high.
// RL6: Seeing the released clock high reloads the counter and restarts it.
// RL7: Released data line sampled low with clock high is a collision.
// RL8: Collision pulses the master event flag and idles the master.
// RL9: Collision in transmit stops shifting, clears buffer full, frees lines.
// RL10: Collision in a condition aborts it and clears its request bit.
// RL11: After collision the bus is watched; a Stop raises master event.
// RL12: After collision a new transmit write starts from the first bit.
// RL13: Software starts only when the bus is seen free.
// RL14: Sleep stops the master logic and aborts any transfer.
// RL15: In CPU idle the block runs unless halt in idle is set.
// RL16: Clock line toggles per rollover; receive bits shift in on rise.
// RL17: Transmit write sets buffer full and starts the counter.
// RL18: Collision sets a sticky collision bit cleared by software.
`timescale 1ns/100ps
`default_nettype none

module icm_master (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire icm_pkg::icm_req_t req,
  output logic [15:0]           rdata,
  input  wire icm_pkg::icm_line_t line_i,
  output icm_pkg::icm_line_t    line_o,
  output icm_pkg::icm_line_t    line_oe,
  input  wire logic             sleep_req,
  input  wire logic             cpu_idle,
  output logic                  irq,
  output logic                  master_event
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Illegal small reloads are raised to the floor so the clock still runs
  function automatic logic [15:0] eff_reload(input logic [15:0] v);
    eff_reload = (v < icm_pkg::MIN_RELOAD) ? icm_pkg::MIN_RELOAD : v;
  endfunction

  function automatic logic [15:0] status_word(input icm_pkg::icm_state_t t);
    status_word = 16'h0000;
    status_word[icm_pkg::STAT_ACK]    = t.ackstat;
    status_word[icm_pkg::STAT_TXACT]  = t.txact;
    status_word[icm_pkg::STAT_COLL]   = t.coll;
    status_word[icm_pkg::STAT_STOP]   = t.stop_seen;
    status_word[icm_pkg::STAT_START]  = t.start_seen;
    status_word[icm_pkg::STAT_RXFULL] = t.rx_full;
    status_word[icm_pkg::STAT_TXFULL] = t.tx_full;
  endfunction

  icm_pkg::icm_state_t s_reg;
  icm_pkg::icm_state_t s_next;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic run;
    logic busy;
    logic tick;
    logic coll;
    logic done;
    logic exp_one;
    logic start_det;
    logic stop_det;
    run       = 1'b0;
    busy      = 1'b0;
    tick      = 1'b0;
    coll      = 1'b0;
    done      = 1'b0;
    exp_one   = 1'b0;
    start_det = 1'b0;
    stop_det  = 1'b0;
    s_next    = s_reg;
    if (!nrst) begin
      s_next          = '0;
      s_next.fsm      = icm_pkg::ST_IDLE;
      s_next.rx_data  = icm_pkg::RST_RX[7:0];
      s_next.tx_data  = icm_pkg::RST_TX[7:0];
      s_next.reload   = icm_pkg::RST_RELOAD;
      s_next.ctrl     = icm_pkg::RST_CTRL;
      s_next.own_addr = icm_pkg::RST_ADDR[9:0];
      s_next.scl_sync = 3'b111;
      s_next.sda_sync = 3'b111;
      s_next.scl_f    = 1'b1;
      s_next.sda_f    = 1'b1;
      s_next.sda_prev = 1'b1;
    end else if (ce) begin
      // --------------------------------------------------------------
      // Pin sampling and bus monitor
      // --------------------------------------------------------------
      s_next.scl_sync = {s_reg.scl_sync[1:0], line_i.scl};
      s_next.sda_sync = {s_reg.sda_sync[1:0], line_i.sda};
      if (s_reg.scl_sync[2] == s_reg.scl_sync[1]) begin
        s_next.scl_f = s_reg.scl_sync[1];
      end
      if (s_reg.sda_sync[2] == s_reg.sda_sync[1]) begin
        s_next.sda_f = s_reg.sda_sync[1];
      end
      s_next.sda_prev = s_reg.sda_f;
      start_det = s_reg.sda_prev & ~s_reg.sda_f & s_reg.scl_f;
      stop_det  = ~s_reg.sda_prev & s_reg.sda_f & s_reg.scl_f;
      s_next.ev_pulse = 1'b0;

      run  = s_reg.ctrl[icm_pkg::CTRL_EN] && !sleep_req &&
             !(cpu_idle && s_reg.ctrl[icm_pkg::CTRL_SIDL]);  // see RL15
      busy = (s_reg.fsm != icm_pkg::ST_IDLE);

      // --------------------------------------------------------------
      // Register bus; hardware sets below override these clears
      // --------------------------------------------------------------
      s_next.rdata = 16'h0000;
      if (req.rd) begin
        case (req.addr)
          icm_pkg::OFS_RX: begin
            s_next.rdata   = {8'h00, s_reg.rx_data};
            s_next.rx_full = 1'b0;
          end
          icm_pkg::OFS_TX:     s_next.rdata = {8'h00, s_reg.tx_data};
          icm_pkg::OFS_RELOAD: s_next.rdata = s_reg.reload;
          icm_pkg::OFS_CTRL:   s_next.rdata = s_reg.ctrl;
          icm_pkg::OFS_STAT:   s_next.rdata = status_word(s_reg);
          icm_pkg::OFS_ADDR:   s_next.rdata = {6'h00, s_reg.own_addr};
          icm_pkg::OFS_EVT: begin
            s_next.rdata = {12'h000, s_reg.evt};
            s_next.evt   = 4'h0;
          end
          icm_pkg::OFS_MASK:   s_next.rdata = {12'h000, s_reg.mask};
          default:             s_next.rdata = 16'h0000;
        endcase
      end
      if (req.wr) begin
        case (req.addr)
          icm_pkg::OFS_TX: begin
            // A write while busy is dropped; the byte in flight is kept
            if (!busy && run) begin
              s_next.tx_data = req.wdata[7:0];
              s_next.tx_full = 1'b1;                       // see RL17
              s_next.txact   = 1'b1;
              s_next.fsm     = icm_pkg::ST_TX;
              s_next.ph      = 2'd0;
              s_next.bitn    = 4'h0;                       // see RL12
              s_next.shift   = req.wdata[7:0];
              s_next.sda_oe  = ~req.wdata[7];
              s_next.cnt     = eff_reload(s_reg.reload);   // see RL17
              s_next.wait_hi = 1'b0;
            end
          end
          icm_pkg::OFS_RELOAD: s_next.reload = req.wdata;  // see RL3
          icm_pkg::OFS_CTRL: begin
            s_next.ctrl = req.wdata;
            // Requests made while busy are disregarded
            if (busy) begin
              s_next.ctrl[4:0] = s_reg.ctrl[4:0];
            end
          end
          icm_pkg::OFS_STAT: begin
            if (!req.wdata[icm_pkg::STAT_COLL]) begin
              s_next.coll = 1'b0;                          // see RL18
            end
          end
          icm_pkg::OFS_ADDR: s_next.own_addr = req.wdata[9:0];
          icm_pkg::OFS_MASK: s_next.mask = req.wdata[3:0];
          default: ;
        endcase
      end

      // --------------------------------------------------------------
      // Clock counter
      // --------------------------------------------------------------
      if (run && busy) begin
        if (s_reg.wait_hi) begin
          if (s_reg.scl_f) begin
            s_next.cnt     = eff_reload(s_reg.reload);     // see RL6
            s_next.wait_hi = 1'b0;
            if (s_reg.fsm == icm_pkg::ST_RX) begin
              s_next.shift = {s_reg.shift[6:0], s_reg.sda_f};  // see RL16
            end
          end
        end else if (s_reg.cnt == 16'h0000) begin
          tick       = 1'b1;                               // see RL1
          s_next.cnt = eff_reload(s_reg.reload);
        end else begin
          s_next.cnt = s_reg.cnt - 16'h0001;               // see RL1
        end
      end

      // A driven-low data bit, receive and the ack slot expect no one
      exp_one = !(s_reg.fsm == icm_pkg::ST_RX) &&
                !(s_reg.fsm == icm_pkg::ST_TX && s_reg.bitn == 4'h8);
      coll = tick && exp_one && !s_reg.scl_oe && !s_reg.sda_oe &&
             s_reg.scl_f && !s_reg.sda_f;                  // see RL7

      // --------------------------------------------------------------
      // Master sequencer; every clock toggle happens on a rollover
      // --------------------------------------------------------------
      if (tick && !coll) begin
        case (s_reg.fsm)
          icm_pkg::ST_START: begin
            if (s_reg.ph == 2'd0) begin
              s_next.sda_oe = 1'b1;
              s_next.ph     = 2'd1;
            end else begin
              s_next.scl_oe = 1'b1;                        // see RL16
              s_next.ctrl[icm_pkg::CTRL_SEN] = 1'b0;
              done = 1'b1;
            end
          end
          icm_pkg::ST_RESTART: begin
            case (s_reg.ph)
              2'd0: s_next.sda_oe = 1'b0;
              2'd1: begin
                s_next.scl_oe  = 1'b0;
                s_next.wait_hi = 1'b1;                     // see RL5
              end
              2'd2: s_next.sda_oe = 1'b1;
              default: begin
                s_next.scl_oe = 1'b1;
                s_next.ctrl[icm_pkg::CTRL_RSEN] = 1'b0;
                done = 1'b1;
              end
            endcase
            s_next.ph = s_reg.ph + 2'd1;
          end
          icm_pkg::ST_STOP: begin
            case (s_reg.ph)
              2'd0: s_next.sda_oe = 1'b1;
              2'd1: begin
                s_next.scl_oe  = 1'b0;
                s_next.wait_hi = 1'b1;                     // see RL5
              end
              default: begin
                s_next.sda_oe = 1'b0;
                s_next.ctrl[icm_pkg::CTRL_PEN] = 1'b0;
                done = 1'b1;
              end
            endcase
            s_next.ph = s_reg.ph + 2'd1;
          end
          icm_pkg::ST_TX, icm_pkg::ST_RX, icm_pkg::ST_ACK: begin
            if (s_reg.ph == 2'd0) begin
              s_next.scl_oe  = 1'b0;                       // see RL16
              s_next.wait_hi = 1'b1;                       // see RL5
              s_next.ph      = 2'd1;
            end else begin
              s_next.scl_oe = 1'b1;                        // see RL16
              s_next.ph     = 2'd0;
              s_next.bitn   = s_reg.bitn + 4'h1;
              case (s_reg.fsm)
                icm_pkg::ST_TX: begin
                  if (s_reg.bitn == icm_pkg::ACK_BIT) begin
                    s_next.ackstat = s_reg.sda_f;
                    s_next.tx_full = 1'b0;
                    s_next.txact   = 1'b0;
                    done = 1'b1;
                  end else begin
                    s_next.shift  = {s_reg.shift[6:0], 1'b0};
                    s_next.sda_oe = (s_reg.bitn == icm_pkg::LAST_BIT) ?
                                    1'b0 : ~s_reg.shift[6];
                  end
                end
                icm_pkg::ST_RX: begin
                  if (s_reg.bitn == icm_pkg::LAST_BIT) begin
                    s_next.rx_data = s_reg.shift;
                    s_next.rx_full = 1'b1;
                    s_next.ctrl[icm_pkg::CTRL_RCEN] = 1'b0;
                    done = 1'b1;
                  end
                end
                default: begin
                  s_next.sda_oe = 1'b0;
                  s_next.ctrl[icm_pkg::CTRL_ACKEN] = 1'b0;
                  done = 1'b1;
                end
              endcase
            end
          end
          default: ;
        endcase
      end

      if (done) begin
        s_next.fsm      = icm_pkg::ST_IDLE;
        s_next.ev_pulse = 1'b1;
        s_next.evt[icm_pkg::EVT_MASTER] = 1'b1;
      end

      // Dispatch one pending request from idle
      if (run && !busy && !(req.wr && req.addr == icm_pkg::OFS_TX)) begin
        s_next.ph      = 2'd0;
        s_next.bitn    = 4'h0;
        s_next.wait_hi = 1'b0;
        s_next.cnt     = eff_reload(s_reg.reload);
        if (s_reg.ctrl[icm_pkg::CTRL_SEN]) begin
          s_next.fsm = icm_pkg::ST_START;
        end else if (s_reg.ctrl[icm_pkg::CTRL_RSEN]) begin
          s_next.fsm = icm_pkg::ST_RESTART;
        end else if (s_reg.ctrl[icm_pkg::CTRL_PEN]) begin
          s_next.fsm = icm_pkg::ST_STOP;
        end else if (s_reg.ctrl[icm_pkg::CTRL_RCEN]) begin
          s_next.fsm    = icm_pkg::ST_RX;
          s_next.sda_oe = 1'b0;
        end else if (s_reg.ctrl[icm_pkg::CTRL_ACKEN]) begin
          s_next.fsm    = icm_pkg::ST_ACK;
          s_next.sda_oe = ~s_reg.ctrl[icm_pkg::CTRL_ACKDT];
        end
      end

      // --------------------------------------------------------------
      // Collision and power abort
      // --------------------------------------------------------------
      if (coll) begin
        s_next.fsm      = icm_pkg::ST_IDLE;                // see RL8
        s_next.ev_pulse = 1'b1;                            // see RL8
        s_next.evt[icm_pkg::EVT_MASTER] = 1'b1;
        s_next.evt[icm_pkg::EVT_COLL]   = 1'b1;
        s_next.coll     = 1'b1;                            // see RL18
        s_next.tx_full  = 1'b0;                            // see RL9
        s_next.txact    = 1'b0;
        s_next.ctrl     = s_reg.ctrl & ~icm_pkg::CTRL_REQ_MASK;  // see RL10
        s_next.sda_oe   = 1'b0;                            // see RL9
        s_next.scl_oe   = 1'b0;
        s_next.wait_hi  = 1'b0;
        s_next.lost     = 1'b1;                            // see RL11
      end
      if (sleep_req || !s_reg.ctrl[icm_pkg::CTRL_EN]) begin
        // Clocks stopped: whatever was in flight is lost, lines let go
        s_next.fsm     = icm_pkg::ST_IDLE;                 // see RL14
        s_next.cnt     = 16'h0000;
        s_next.wait_hi = 1'b0;
        s_next.sda_oe  = 1'b0;
        s_next.scl_oe  = 1'b0;
        s_next.txact   = 1'b0;
        s_next.tx_full = 1'b0;
      end

      if (start_det) begin
        s_next.start_seen = 1'b1;
        s_next.stop_seen  = 1'b0;
        s_next.evt[icm_pkg::EVT_START] = 1'b1;
      end
      if (stop_det) begin
        s_next.stop_seen  = 1'b1;
        s_next.start_seen = 1'b0;
        s_next.evt[icm_pkg::EVT_STOP] = 1'b1;
        if (s_reg.lost) begin
          s_next.lost     = 1'b0;
          s_next.ev_pulse = 1'b1;                          // see RL11
          s_next.evt[icm_pkg::EVT_MASTER] = 1'b1;
        end
      end
      s_next.irq = |(s_next.evt & s_next.mask);
    end
  end

  always_ff @(posedge mclk) begin
    s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata        = s_reg.rdata;
  assign line_o       = '0;
  assign line_oe.scl  = s_reg.scl_oe;
  assign line_oe.sda  = s_reg.sda_oe;
  assign irq          = s_reg.irq;
  assign master_event = s_reg.ev_pulse;

endmodule

`default_nettype wire

// ---- icm_master_monitor.sv ----
// Port checker for the two-wire master clocking block
`timescale 1ns/100ps
`default_nettype none

module icm_master_monitor (
  input wire logic               mclk,
  input wire logic               nrst,
  input wire logic               ce,
  input wire icm_pkg::icm_req_t  req,
  input wire logic [15:0]        rdata,
  input wire icm_pkg::icm_line_t line_i,
  input wire icm_pkg::icm_line_t line_o,
  input wire icm_pkg::icm_line_t line_oe,
  input wire logic               sleep_req,
  input wire logic               cpu_idle,
  input wire logic               irq,
  input wire logic               master_event
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Sync lag plus the shortest count keeps the high phase this long
  sequence scl_freed_rise;
    $rose(line_i.scl) && !line_oe.scl;
  endsequence
  sequence scl_kept_high;
    !line_oe.scl [*6];
  endsequence

  high_phase_min_a: assert property (scl_freed_rise |-> scl_kept_high)
    else $error("clock high phase cut short");
  stretch_pause_a: assert property (!line_oe.scl && !line_i.scl |=>
    !line_oe.scl) else $error("clock pulled while held low");
  sleep_release_a: assert property (sleep_req [*3] |-> line_oe == '0)
    else $error("lines held during sleep");
  event_pulse_a: assert property (master_event && ce |=> !master_event)
    else $error("master event longer than a cycle");
  open_drain_a: assert property (line_o == '0)
    else $error("line driven high");
  read_window_a: assert property (!$past(req.rd) |-> rdata == 16'h0000)
    else $error("read data outside its cycle");
  write_quiet_a: assert property (req.wr |=> rdata == 16'h0000)
    else $error("read data after a write");
  reset_quiet_a: assert property (!$past(nrst) |-> line_oe == '0 && !irq
    && !master_event) else $error("outputs active after reset");
endmodule

bind icm_master icm_master_monitor u_mon (.mclk(mclk), .nrst(nrst),
  .ce(ce), .req(req), .rdata(rdata), .line_i(line_i), .line_o(line_o),
  .line_oe(line_oe), .sleep_req(sleep_req), .cpu_idle(cpu_idle),
  .irq(irq), .master_event(master_event));
`default_nettype wire

// ---- icm_partner.sv ----
// Far-side bus device: clock stretcher, bit capture, collision maker
`timescale 1ns/100ps
`default_nettype none

module icm_partner (
  input  wire logic  lclk,
  input  wire logic  scl,
  input  wire logic  sda,
  input  wire logic  stretch,
  input  wire logic  collide,
  output logic       scl_low,
  output var logic   sda_low,
  output var logic [8:0] cap
);
  logic       scl_q = 1'h1;
  logic [1:0] hold = 2'h0;

  initial sda_low = 1'h0;
  initial cap = 9'h000;
  assign scl_low = (hold != 2'h0);
  // Data is stable while the clock is high, so take it on the rise
  always @(posedge scl) cap <= {cap[7:0], sda};
  always @(posedge lclk) begin
    scl_q <= scl;
    if (stretch && scl_q && !scl) hold <= 2'h3;
    else if (hold != 2'h0) hold <= hold - 2'h1;
    // Pull only with the clock low; let go as soon as collide drops, which the bus sees as a Stop if the clock is high
    if (!collide) sda_low <= 1'h0;
    else if (!scl) sda_low <= 1'h1;
  end
endmodule
`default_nettype wire

// ---- icm_master_bench.sv ----
// Self-checking bench for the two-wire master clocking block
`timescale 1ns/100ps
`default_nettype none

module icm_master_bench;
  logic               mclk = 1'h0;
  logic               lclk = 1'h0;
  logic               nrst = 1'h0;
  logic               ce = 1'h1;
  logic               sleep_req = 1'h0;
  logic               cpu_idle = 1'h1;
  logic               stretch = 1'h0;
  logic               collide = 1'h0;
  logic               p_scl_low;
  logic               p_sda_low;
  logic [8:0]         cap;
  logic [15:0]        rdata;
  logic [15:0]        d;
  logic               irq;
  logic               master_event;
  icm_pkg::icm_req_t  req = '0;
  icm_pkg::icm_line_t line_i;
  icm_pkg::icm_line_t line_o;
  icm_pkg::icm_line_t line_oe;
  int                 miscompares = 0;
  int                 total_checks = 0;
  int                 ev_count = 0;

  // Pull-ups on both wires: low if anyone pulls
  assign line_i.scl = !(line_oe.scl || p_scl_low);
  assign line_i.sda = !(line_oe.sda || p_sda_low);

  icm_master uut (.mclk(mclk), .nrst(nrst), .ce(ce), .req(req),
    .rdata(rdata), .line_i(line_i), .line_o(line_o), .line_oe(line_oe),
    .sleep_req(sleep_req), .cpu_idle(cpu_idle), .irq(irq),
    .master_event(master_event));
  icm_partner u_far (.lclk(lclk), .scl(line_i.scl), .sda(line_i.sda),
    .stretch(stretch), .collide(collide), .scl_low(p_scl_low),
    .sda_low(p_sda_low), .cap(cap));

  always #5 mclk = ~mclk;
  initial begin
    #3;
    forever #62.5 lclk = ~lclk;
  end
  always @(posedge mclk) if (master_event === 1'h1) ev_count <= ev_count + 1;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge mclk);
    req <= '{addr: a, wdata: v, wr: 1'h1, rd: 1'h0};
    @(posedge mclk);
    req.wr <= 1'h0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge mclk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'h0, rd: 1'h1};
    @(posedge mclk);
    req.rd <= 1'h0;
    // Data stand for this one cycle; take them at its closing edge
    @(posedge mclk);
    d = rdata;
  endtask
  task automatic wait_ev;
    int t0;
    int i;
    t0 = ev_count;
    for (i = 0; i < 4000 && ev_count == t0; i++) @(posedge mclk);
    chk({15'h0000, ev_count == t0}, 16'h0000);
  endtask
  task automatic send(input logic [7:0] b);
    wr(icm_pkg::OFS_TX, {8'h00, b});
    rd(icm_pkg::OFS_STAT);
    chk(d & 16'h4001, 16'h4001);
    wait_ev;
    chk({7'h00, cap}, {7'h00, b, 1'h1});
  endtask
  task automatic conclude;
    if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [15:0] ofs [9];
    logic [15:0] rst [9];
    ofs = '{16'h0200, 16'h0202, 16'h0204, 16'h0206, 16'h0208, 16'h020a,
      16'h020c, 16'h020e, 16'h0210};
    rst = '{16'h0000, 16'h00ff, 16'h0000, 16'h1000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000};
    for (int k = 0; k < 9; k++) begin
      rd(ofs[k]);
      chk(d, rst[k]);
    end
    wr(icm_pkg::OFS_RX, 16'h1234);
    rd(icm_pkg::OFS_RX);
    chk(d, 16'h0000);
    wr(icm_pkg::OFS_ADDR, 16'hffff);
    rd(icm_pkg::OFS_ADDR);
    chk(d, 16'h03ff);
  endtask
  task automatic t_tx;
    // Reload for a 4 MHz line clock (25 cycles per period) from the 100 MHz system clock
    wr(icm_pkg::OFS_RELOAD, 16'h0009);
    wr(icm_pkg::OFS_MASK, 16'h0001);
    wr(icm_pkg::OFS_CTRL, 16'h8001);
    wait_ev;
    chk({15'h0000, irq}, 16'h0001);
    rd(icm_pkg::OFS_EVT);
    chk(d & 16'h0001, 16'h0001);
    repeat (3) @(posedge mclk);
    chk({15'h0000, irq}, 16'h0000);
    send(8'ha5);
    stretch <= 1'h1;
    send(8'h3c);
    stretch <= 1'h0;
    wr(icm_pkg::OFS_CTRL, 16'h8004);
    wait_ev;
  endtask
  task automatic t_coll;
    wr(icm_pkg::OFS_MASK, 16'h0000);
    wr(icm_pkg::OFS_CTRL, 16'h8001);
    wait_ev;
    collide <= 1'h1;
    repeat (30) @(posedge mclk);
    wr(icm_pkg::OFS_TX, 16'h00ff);
    wait_ev;
    chk({14'h0000, line_oe}, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    rd(icm_pkg::OFS_STAT);
    chk(d & 16'h0401, 16'h0400);
    wr(icm_pkg::OFS_MASK, 16'h0002);
    repeat (3) @(posedge mclk);
    chk({15'h0000, irq}, 16'h0001);
    collide <= 1'h0;
    wait_ev;
    rd(icm_pkg::OFS_EVT);
    chk(d & 16'h0006, 16'h0006);
    wr(icm_pkg::OFS_STAT, 16'h0000);
    rd(icm_pkg::OFS_STAT);
    chk(d & 16'h0400, 16'h0000);
    wr(icm_pkg::OFS_CTRL, 16'h8001);
    wait_ev;
    send(8'h81);
    wr(icm_pkg::OFS_CTRL, 16'h8008);
    wait_ev;
    rd(icm_pkg::OFS_RX);
    chk(d, 16'h00ff);
    wr(icm_pkg::OFS_CTRL, 16'h8010);
    wait_ev;
    chk({15'h0000, cap[0]}, 16'h0000);
    wr(icm_pkg::OFS_CTRL, 16'h8002);
    wait_ev;
    wr(icm_pkg::OFS_CTRL, 16'h8004);
    wait_ev;
  endtask
  task automatic t_sleep;
    wr(icm_pkg::OFS_CTRL, 16'h8001);
    wait_ev;
    wr(icm_pkg::OFS_TX, 16'h0055);
    repeat (40) @(posedge mclk);
    sleep_req <= 1'h1;
    wr(icm_pkg::OFS_TX, 16'h0066);
    chk({14'h0000, line_oe}, 16'h0000);
    rd(icm_pkg::OFS_STAT);
    chk(d & 16'h0001, 16'h0000);
    sleep_req <= 1'h0;
  endtask
  task automatic t_idle;
    int n;
    wr(icm_pkg::OFS_CTRL, 16'ha001);
    n = ev_count;
    repeat (200) @(posedge mclk);
    chk({15'h0000, ev_count != n}, 16'h0000);
    // Enable low must freeze the start that leaving idle would release
    ce <= 1'h0;
    cpu_idle <= 1'h0;
    repeat (100) @(posedge mclk);
    chk({15'h0000, ev_count != n}, 16'h0000);
    ce <= 1'h1;
    wait_ev;
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'h1;
    t_regs;
    t_tx;
    t_coll;
    t_sleep;
    t_idle;
    conclude;
  end
  initial begin
    #500000;
    chk(16'h0000, 16'h0001);
    conclude;
  end
endmodule
`default_nettype wire
